// ===== inc/cms_pkg.sv
// shared constants and types of the mute and power sequencing block
package cms_pkg;
  // ********************************************************
  // clocking and timing
  // ********************************************************
  localparam int unsigned CLK_FREQ_KHZ = 40000;
  localparam int unsigned WAIT_FRAMES  = 1045;
  localparam int unsigned RAMP_TIME_MS = 400;
  localparam int unsigned RAMP_CYCLES  = RAMP_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned AUTO_LIMIT   = 8192;
  // ********************************************************
  // widths
  // ********************************************************
  localparam int unsigned SAMPLE_W  = 24;
  localparam int unsigned HPF_SHIFT = 10;
  localparam int unsigned ACC_W     = SAMPLE_W + HPF_SHIFT;
  localparam int unsigned AUTO_W    = 14;
  // ********************************************************
  // register offsets
  // ********************************************************
  localparam logic [7:0] REG_ID     = 8'h01;
  localparam logic [7:0] REG_POWER  = 8'h02;
  localparam logic [7:0] REG_MODE   = 8'h03;
  localparam logic [7:0] REG_ADCDAC = 8'h04;
  localparam logic [7:0] REG_MUTE   = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int unsigned PWR_PDN     = 0;
  localparam int unsigned PWR_PDN_DAC = 1;
  localparam int unsigned PWR_PDN_ADC = 5;
  localparam int unsigned MODE_SPD_LO = 4;
  localparam int unsigned ADC_FRZ_L   = 7;
  localparam int unsigned ADC_FRZ_R   = 6;
  localparam int unsigned MUTE_AUTO   = 0;
  localparam int unsigned MUTE_L      = 1;
  localparam int unsigned MUTE_R      = 2;
  localparam int unsigned MUTE_DEEMPH = 3;
  localparam logic [7:0] POWER_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h30;
  localparam logic [7:0] ADCDAC_RST = 8'h00;
  localparam logic [7:0] MUTE_RST   = 8'h01;
  // ********************************************************
  // speed modes and oversampling ratios
  // ********************************************************
  localparam logic [1:0] SPD_SINGLE = 2'h0;
  localparam logic [1:0] SPD_DOUBLE = 2'h1;
  localparam logic [1:0] SPD_QUAD   = 2'h2;
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DOUBLE = 8'h40;
  localparam logic [7:0] OSR_QUAD   = 8'h20;
  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [3:0] {
    ST_CLAMP = 4'h1,
    ST_RAMP  = 4'h2,
    ST_RUN   = 4'h4,
    ST_PDN   = 4'h8
  } cms_state_e;
  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } cms_pair_s;
endpackage

// ===== hw/cms_ctrl.sv
// mute, power sequencing, speed mode and high-pass filter control
// Behaviour
// - each input channel has its own dc-removing high-pass filter
// - frozen filter keeps its stored dc offset and keeps subtracting it
// - oversampling mode follows the speed-mode field of mode register
// - single speed, 4 to 54 kHz, runs at 128x oversampling
// - double speed, 50 to 108 kHz, runs at 64x oversampling
// - quad speed, 100 to 216 kHz, runs at 32x oversampling
// - reset toggling alone starts the transient-suppression sequence
// - outputs clamped at power-up, ramp starts after 1045 sample periods
// - audio passes only after the ramp ends, about 0.4 s later
// - power-down stops audio and switches outputs to a soft sink
// - de-emphasis only in single speed, defined at 44.1 kHz
// - mute during power-up, reset, mute, bad clock ratio, power-down
// - automatic muting is enabled out of reset
// - channel mutes after 8192 consecutive static samples
// - one non-static sample releases that channel's automatic mute
// - mute outputs are low while muted, high otherwise
// - a static sample is all zeros or minus one
// - static counting and auto-mute are separate per channel
//
// Chosen here: the placing of the registers and the strobed register port.
module cms_ctrl #(
  parameter int unsigned WAIT_FRAMES_P = cms_pkg::WAIT_FRAMES,
  parameter int unsigned RAMP_CYCLES_P = cms_pkg::RAMP_CYCLES,
  parameter logic [7:0]  DEVICE_ID     = 8'h5A // arbitrary value
) (
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic              FRAME_CLOCK,
  input  wire logic              RATIO_BAD,
  input  wire logic              ADC_VALID,
  input  wire cms_pkg::cms_pair_s ADC_IN,
  output cms_pkg::cms_pair_s     ADC_OUT,
  input  wire logic              DAC_VALID,
  input  wire cms_pkg::cms_pair_s DAC_IN,
  output cms_pkg::cms_pair_s     DAC_OUT,
  output logic [7:0]             OSR_RATIO,
  output logic                   DEEMPH_ACTIVE,
  output logic                   OUT_CLAMP,
  output logic                   OUT_RAMP,
  output logic                   OUT_SINK,
  output logic                   AUDIO_EN,
  output logic                   MUTE_LEFT_N,
  output logic                   MUTE_RIGHT_N
);
  import cms_pkg::*;

  // ********************************************************
  // functions
  // ********************************************************
  function automatic logic is_static(input logic [SAMPLE_W-1:0] s);
    is_static = (s == '0) || (s == '1);
  endfunction

  function automatic logic [ACC_W-1:0] hpf_acc(
    input logic [ACC_W-1:0]    acc,
    input logic [SAMPLE_W-1:0] x);
    logic signed [ACC_W-1:0] xs;
    logic signed [ACC_W-1:0] dc;
    xs = ACC_W'(signed'(x));
    dc = signed'(acc) >>> HPF_SHIFT;
    hpf_acc = ACC_W'(signed'(acc) + xs - dc);
  endfunction

  function automatic logic [SAMPLE_W-1:0] hpf_out(
    input logic [ACC_W-1:0]    acc,
    input logic [SAMPLE_W-1:0] x);
    logic [SAMPLE_W-1:0] dc;
    dc = acc[ACC_W-1:HPF_SHIFT];
    hpf_out = x - dc;
  endfunction

  // ********************************************************
  // registers
  // ********************************************************
  logic [7:0] power;
  logic [7:0] mode;
  logic [7:0] adcdac;
  logic [7:0] mute_ctl;
  logic [7:0] status;
  cms_state_e state;
  cms_state_e next_state;
  logic       auto_l;
  logic       auto_r;
  logic [1:0] speed;
  logic       pdn_any;

  // speed field reset value selects single speed (slave detect)
  assign speed   = mode[MODE_SPD_LO +: 2];
  assign pdn_any = power[PWR_PDN] | power[PWR_PDN_DAC];

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      power    <= POWER_RST;
      mode     <= MODE_RST;
      adcdac   <= ADCDAC_RST;
      mute_ctl <= MUTE_RST;
    end else if (WR) begin
      case (ADDR)
        REG_POWER:  power    <= WDATA;
        REG_MODE:   mode     <= WDATA;
        REG_ADCDAC: adcdac   <= WDATA;
        REG_MUTE:   mute_ctl <= WDATA;
        default: begin
        end
      endcase
    end
  end

  // bit2 covers the clamp and power-down states; ramp, also without audio, has bit1
  assign status = {2'h0, RATIO_BAD, auto_r, auto_l,
                   (state == ST_CLAMP) || (state == ST_PDN),
                   state == ST_RAMP, state == ST_RUN};

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        REG_ID:     RDATA <= DEVICE_ID;
        REG_POWER:  RDATA <= power;
        REG_MODE:   RDATA <= mode;
        REG_ADCDAC: RDATA <= adcdac;
        REG_MUTE:   RDATA <= mute_ctl;
        REG_STATUS: RDATA <= status;
        default:    RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ********************************************************
  // frame clock synchroniser, one tick per sample period
  // ********************************************************
  logic frame_s1;
  logic frame_s2;
  logic frame_s3;
  logic frame_tick;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      frame_s3 <= 1'b0;
    end else begin
      frame_s1 <= FRAME_CLOCK;
      frame_s2 <= frame_s1;
      frame_s3 <= frame_s2;
    end
  end
  assign frame_tick = frame_s2 & ~frame_s3;

  // ********************************************************
  // speed mode and de-emphasis
  // ********************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OSR_RATIO     <= OSR_SINGLE;
      DEEMPH_ACTIVE <= 1'b0;
    end else begin
      case (speed)
        SPD_DOUBLE: OSR_RATIO <= OSR_DOUBLE;
        SPD_QUAD:   OSR_RATIO <= OSR_QUAD;
        default:    OSR_RATIO <= OSR_SINGLE;
      endcase
      DEEMPH_ACTIVE <= mute_ctl[MUTE_DEEMPH] &&
                       (OSR_RATIO == OSR_SINGLE) &&
                       (speed != SPD_DOUBLE) && (speed != SPD_QUAD);
    end
  end

  // ********************************************************
  // power sequencing
  // ********************************************************
  logic [11:0] wait_cnt;
  logic [31:0] ramp_cnt;
  logic        wait_done;
  logic        ramp_done;

  assign wait_done = frame_tick &&
                     (wait_cnt == 12'(WAIT_FRAMES_P - 1));
  assign ramp_done = (ramp_cnt == 32'(RAMP_CYCLES_P - 1));

  always_comb begin
    next_state = state;
    case (state)
      // clamp held for the wait in sample periods
      ST_CLAMP: if (wait_done) next_state = ST_RAMP;
      // audio only once the ramp has run out
      ST_RAMP:  if (ramp_done) next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      // leaving power-down restarts the power-up sequence
      ST_PDN:   next_state = ST_CLAMP;
      default:  next_state = ST_CLAMP;
    endcase
    if (pdn_any) next_state = ST_PDN;
  end

  // reset alone enters the clamp state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_CLAMP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_cnt <= 12'h000;
      ramp_cnt <= 32'h0000_0000;
    end else begin
      if (state != ST_CLAMP) wait_cnt <= 12'h000;
      else if (frame_tick) wait_cnt <= wait_cnt + 12'h001;
      if (state != ST_RAMP) ramp_cnt <= 32'h0000_0000;
      else ramp_cnt <= ramp_cnt + 32'h0000_0001;
    end
  end

  assign OUT_CLAMP = (state == ST_CLAMP);
  assign OUT_RAMP  = (state == ST_RAMP);
  assign OUT_SINK  = (state == ST_PDN);
  assign AUDIO_EN  = (state == ST_RUN);

  // ********************************************************
  // automatic mute, one counter per channel
  // ********************************************************
  logic [AUTO_W-1:0] cnt_l;
  logic [AUTO_W-1:0] cnt_r;
  logic              mute_l;
  logic              mute_r;

  // clear on non-static sample or power-down
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_l <= '0;
      cnt_r <= '0;
    end else if (pdn_any) begin
      cnt_l <= '0;
      cnt_r <= '0;
    end else if (DAC_VALID) begin
      // zeros or minus one count as static
      if (!is_static(DAC_IN.left)) cnt_l <= '0;
      else if (cnt_l != AUTO_W'(AUTO_LIMIT)) cnt_l <= cnt_l + 1'b1;
      if (!is_static(DAC_IN.right)) cnt_r <= '0;
      else if (cnt_r != AUTO_W'(AUTO_LIMIT)) cnt_r <= cnt_r + 1'b1;
    end
  end

  // mute after the full static run
  // counter clear drops the auto-mute at once
  assign auto_l = mute_ctl[MUTE_AUTO] && (cnt_l == AUTO_W'(AUTO_LIMIT));
  assign auto_r = mute_ctl[MUTE_AUTO] && (cnt_r == AUTO_W'(AUTO_LIMIT));

  // every mute cause folded into one term
  assign mute_l = !AUDIO_EN || RATIO_BAD || mute_ctl[MUTE_L] || auto_l;
  assign mute_r = !AUDIO_EN || RATIO_BAD || mute_ctl[MUTE_R] || auto_r;

  // active low pins, low during reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MUTE_LEFT_N  <= 1'b0;
      MUTE_RIGHT_N <= 1'b0;
    end else begin
      MUTE_LEFT_N  <= !mute_l;
      MUTE_RIGHT_N <= !mute_r;
    end
  end

  // muted samples go out as zero so the common mode is kept
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DAC_OUT <= '0;
    end else if (DAC_VALID) begin
      DAC_OUT.left  <= mute_l ? '0 : DAC_IN.left;
      DAC_OUT.right <= mute_r ? '0 : DAC_IN.right;
    end
  end

  // ********************************************************
  // high-pass filters
  // ********************************************************
  logic [ACC_W-1:0] acc_l;
  logic [ACC_W-1:0] acc_r;

  // freeze holds the accumulator, subtraction continues
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_l   <= '0;
      acc_r   <= '0;
      ADC_OUT <= '0;
    end else if (ADC_VALID) begin
      if (!adcdac[ADC_FRZ_L]) acc_l <= hpf_acc(acc_l, ADC_IN.left);
      if (!adcdac[ADC_FRZ_R]) acc_r <= hpf_acc(acc_r, ADC_IN.right);
      ADC_OUT.left  <= hpf_out(acc_l, ADC_IN.left);
      ADC_OUT.right <= hpf_out(acc_r, ADC_IN.right);
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_osr_quad_sel: assert property (
    (speed == SPD_QUAD) [*2] |-> OSR_RATIO == OSR_QUAD)
    else $error("quad speed ratio wrong");
  a_osr_dbl_sel: assert property (
    (speed == SPD_DOUBLE) [*2] |-> OSR_RATIO == OSR_DOUBLE)
    else $error("double speed ratio wrong");
  a_deemph_single: assert property (
    DEEMPH_ACTIVE |-> $past(speed) != SPD_DOUBLE &&
                      $past(speed) != SPD_QUAD)
    else $error("de-emphasis outside single speed");
  a_ramp_start: assert property (
    state == ST_CLAMP && wait_done && !pdn_any |=> OUT_RAMP && !OUT_CLAMP)
    else $error("ramp did not start after wait");
  a_clamp_early: assert property (
    $rose(OUT_RAMP) |-> $past(wait_cnt) == 12'(WAIT_FRAMES_P - 1))
    else $error("ramp started early");
  a_audio_after: assert property (
    $rose(AUDIO_EN) |-> $past(OUT_RAMP) && $past(ramp_done))
    else $error("audio before ramp end");
  a_pdn_sink: assert property (
    pdn_any |=> OUT_SINK && !AUDIO_EN ##1 !MUTE_LEFT_N && !MUTE_RIGHT_N)
    else $error("power-down not honoured");
  a_mute_notrun: assert property (
    !AUDIO_EN || RATIO_BAD |=> !MUTE_LEFT_N && !MUTE_RIGHT_N)
    else $error("mute missing");
  a_auto_set: assert property (
    mute_ctl[MUTE_AUTO] && cnt_l == AUTO_W'(AUTO_LIMIT) |=> !MUTE_LEFT_N)
    else $error("auto-mute not asserted");
  a_auto_release: assert property (
    DAC_VALID && !pdn_any && !is_static(DAC_IN.right) |=>
      cnt_r == '0 ##1 !auto_r)
    else $error("auto-mute not released");
  a_static_clear: assert property (
    pdn_any |=> cnt_l == '0 && cnt_r == '0)
    else $error("static counter not cleared");
  a_freeze_hold: assert property (
    adcdac[ADC_FRZ_L] |=> acc_l == $past(acc_l))
    else $error("frozen offset changed");
  a_hpf_sub: assert property (
    ADC_VALID |=> ADC_OUT.right ==
      $past(hpf_out(acc_r, ADC_IN.right)))
    else $error("filter output wrong");

  c_reach_run: cover property ($rose(AUDIO_EN));
  c_auto_mute: cover property ($fell(MUTE_LEFT_N) && AUDIO_EN);
  c_pdn_run: cover property (AUDIO_EN ##1 OUT_SINK);
  c_freeze: cover property (adcdac[ADC_FRZ_R] && ADC_VALID);
endmodule // cms_ctrl

// ===== testbench/cms_host_model.sv
// partner model: shared frame clock source and external mute circuit
module cms_host_model #(
  parameter int unsigned HALF_FRAME = 4
) (
  input  wire logic CLK,
  input  wire logic ARST_N,
  input  wire logic MUTE_LEFT_N,
  input  wire logic MUTE_RIGHT_N,
  output logic      FRAME_CLOCK,
  output logic      ext_mute_l,
  output logic      ext_mute_r
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] div;
  // one frame source, restarted with the shared reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div         <= 8'h00;
      FRAME_CLOCK <= 1'b0;
    end else if (div == 8'(HALF_FRAME - 1)) begin
      div         <= 8'h00;
      FRAME_CLOCK <= ~FRAME_CLOCK;
    end else begin
      div <= div + 8'h01;
    end
  end
  assign ext_mute_l = ~MUTE_LEFT_N;
  assign ext_mute_r = ~MUTE_RIGHT_N;
endmodule // cms_host_model

// ===== testbench/tb.sv
// self-checking bench of the mute and power sequencing block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cms_pkg::*;
  // short counts keep the run brief; expectations follow them
  localparam int unsigned WAITF = 40;
  localparam int unsigned RAMPC = 20;
  localparam logic [7:0] OSR_T [4] = '{OSR_SINGLE, OSR_DOUBLE, OSR_QUAD,
                                       OSR_SINGLE};
  logic        CLK, ARST_N, WR, RD, RATIO_BAD, ADC_VALID, DAC_VALID;
  logic        FRAME_CLOCK, DEEMPH_ACTIVE, OUT_CLAMP, OUT_RAMP, OUT_SINK;
  logic        AUDIO_EN, MUTE_LEFT_N, MUTE_RIGHT_N, mute_l, mute_r;
  logic        rd_d, adc_d;
  logic [7:0]  ADDR, WDATA, RDATA, OSR_RATIO;
  logic [31:0] lf;
  cms_pair_s   ADC_IN, ADC_OUT, DAC_IN, DAC_OUT;
  int          failures, n_tests, k;
  int unsigned cyc = 0;
  int unsigned r0;
  logic [7:0]  rq[$];
  cms_pair_s   aq[$];

  cms_ctrl #(.WAIT_FRAMES_P(WAITF), .RAMP_CYCLES_P(RAMPC)) cms_ctrl_inst (
    .CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .FRAME_CLOCK,
    .RATIO_BAD, .ADC_VALID, .ADC_IN, .ADC_OUT, .DAC_VALID, .DAC_IN,
    .DAC_OUT, .OSR_RATIO, .DEEMPH_ACTIVE, .OUT_CLAMP, .OUT_RAMP,
    .OUT_SINK, .AUDIO_EN, .MUTE_LEFT_N, .MUTE_RIGHT_N);
  cms_host_model cms_host_model_inst (
    .CLK, .ARST_N, .MUTE_LEFT_N, .MUTE_RIGHT_N, .FRAME_CLOCK,
    .ext_mute_l(mute_l), .ext_mute_r(mute_r));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) cyc <= cyc + 1;

  // ********************************************************
  // bus, stream and compare tasks
  // ********************************************************
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    rq.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic adc(input logic [47:0] x, input logic [47:0] e);
    @(posedge CLK);
    ADC_VALID <= 1'b1;
    ADC_IN    <= x;
    aq.push_back(e);
    @(posedge CLK);
    ADC_VALID <= 1'b0;
  endtask
  task automatic dac(input logic [23:0] l, input logic [23:0] r);
    @(posedge CLK);
    DAC_VALID <= 1'b1;
    DAC_IN    <= {l, r};
    @(posedge CLK);
    DAC_VALID <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // results show one cycle after their strobe
  always @(posedge CLK) begin
    if (rd_d) check(48'(RDATA), 48'(rq.pop_front()));
    if (adc_d) check(ADC_OUT, aq.pop_front());
    rd_d  <= RD;
    adc_d <= ADC_VALID;
  end

  initial begin
    #(60000 * 25);
    failures++;
    conclude();
  end

  // ********************************************************
  // scenarios
  // ********************************************************
  initial begin
    {ARST_N, WR, RD, RATIO_BAD, ADC_VALID, DAC_VALID, rd_d, adc_d} = '0;
    {ADDR, WDATA, ADC_IN, DAC_IN} = '0;
    failures = 0;
    n_tests  = 0;
    lf       = 32'hb3b1;
    repeat (16) @(posedge CLK);
    ARST_N <= 1'b1;
    r0 = cyc;
    @(negedge CLK);
    check(48'({OUT_CLAMP, OUT_RAMP, AUDIO_EN, mute_l, mute_r}), 48'h13);
    rd(REG_MODE, MODE_RST);
    rd(REG_MUTE, MUTE_RST);
    rd(REG_POWER, POWER_RST);
    rd(REG_ADCDAC, ADCDAC_RST);
    wr(REG_ID, 8'hFF);
    rd(REG_ID, 8'h5A);
    rd(8'h7F, 8'h00);
    wr(REG_MUTE, 8'h09);
    for (int s = 0; s < 4; s++) begin
      wr(REG_MODE, 8'(s << 4));
      wait_n(3);
      check(48'(OSR_RATIO), 48'(OSR_T[s]));
      check(48'(DEEMPH_ACTIVE), 48'(s == 0 || s == 3));
    end
    wr(REG_MUTE, MUTE_RST);
    // empty accumulators pass the first sample untouched
    adc({24'h100000, 24'h100000}, {24'h100000, 24'h100000});
    wr(REG_ADCDAC, 8'h80);
    adc({24'h001000, 24'h001000}, {24'h000C00, 24'h000C00});
    adc({24'h001000, 24'h001000}, {24'h000C00, 24'h000BFD});
    k = 0;
    while (OUT_RAMP !== 1'b1 && k < 600) begin
      @(negedge CLK);
      k++;
    end
    r0 = cyc - r0;
    check(48'(r0 >= (WAITF - 1) * 8 && r0 <= (WAITF + 2) * 8), 48'h1);
    k = 0;
    while (AUDIO_EN !== 1'b1 && k < 100) begin
      @(negedge CLK);
      k++;
    end
    check(48'(k), 48'(RAMPC));
    wait_n(2);
    check(48'({mute_l, mute_r}), 48'h0);
    // alternating 0 and -1 are both static; right never is
    for (int i = 0; i < AUTO_LIMIT; i++) begin
      lf = nxt(lf);
      if (i == AUTO_LIMIT - 1) begin
        wait_n(3);
        check(48'(mute_l), 48'h0);
      end
      dac({24{i[0]}}, {1'b0, lf[22:1], 1'b1});
    end
    wait_n(3);
    check(48'({mute_l, mute_r}), 48'h2);
    dac(24'h000123, 24'h000123);
    wait_n(3);
    check(48'(mute_l), 48'h0);
    wr(REG_MUTE, 8'h05);
    wait_n(3);
    check(48'({mute_l, mute_r}), 48'h1);
    wr(REG_MUTE, MUTE_RST);
    @(posedge CLK);
    RATIO_BAD <= 1'b1;
    wait_n(3);
    check(48'({mute_l, mute_r}), 48'h3);
    @(posedge CLK);
    RATIO_BAD <= 1'b0;
    wait_n(3);
    check(48'({mute_l, mute_r}), 48'h0);
    wr(REG_POWER, 8'h01);
    wait_n(3);
    check(48'({OUT_SINK, AUDIO_EN, mute_l, mute_r}), 48'hB);
    // power-down held while the blocking capacitors discharge
    repeat (200) @(posedge CLK);
    wr(REG_POWER, 8'h00);
    wait_n(3);
    check(48'({OUT_CLAMP, OUT_SINK, AUDIO_EN}), 48'h4);
    rd(REG_STATUS, 8'h04);
    wr(REG_MUTE, 8'h08);
    @(posedge CLK);
    ARST_N <= 1'b0;
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    @(negedge CLK);
    check(48'({OUT_CLAMP, OUT_SINK, mute_l, mute_r}), 48'hB);
    rd(REG_MUTE, MUTE_RST);
    wait_n(4);
    conclude();
  end
endmodule // tb
